// file: rtl/srap_pkg.sv
// Shared constants and types for the serial register access port
package srap_pkg;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] SRAP_IDX_RST     = 8'h00;
  localparam logic [7:0] SRAP_DATA_RST    = 8'h00;
  localparam logic [2:0] SRAP_BIT_CNT_RST = 3'h0;
  localparam logic [2:0] SRAP_BIT_LAST    = 3'h7;
  localparam logic       SRAP_DIR_WRITE   = 1'b1;

  // ----------------------------------------------------------------
  // Frame phase, Gray coded along command -> index -> data
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRAP_PH_CMD  = 2'b00,
    SRAP_PH_IDX  = 2'b01,
    SRAP_PH_DATA = 2'b11
  } srap_phase_type;

endpackage

// file: rtl/srap_link_if.sv
// Carrier between the link-clock shifter and the system-clock core
interface srap_link_if;
  logic       hdr_tgl;
  logic       dat_tgl;
  logic       dir;
  logic [7:0] idx;
  logic [7:0] data;
  logic [7:0] rd_byte;

  modport link (
    output hdr_tgl,
    output dat_tgl,
    output dir,
    output idx,
    output data,
    input  rd_byte
  );

  modport sys (
    input  hdr_tgl,
    input  dat_tgl,
    input  dir,
    input  idx,
    input  data,
    output rd_byte
  );
endinterface

// file: rtl/srap_spi_shift.sv
// Link-clock side: SPI bit shifter, header decode and read shift-out
module srap_spi_shift
  import srap_pkg::*;
(
  input  wire logic  sclk_i,
  input  wire logic  cs_n_i,
  input  wire logic  nrst_i,
  input  wire logic  mosi_i,
  output logic       miso_o,
  output logic       miso_oe_o,
  srap_link_if.link  lk
);

  logic [2:0]     bit_cnt_reg;
  logic [6:0]     shift_reg;
  logic [7:0]     out_reg;
  srap_phase_type phase_reg;
  logic [7:0]     byte_in;
  logic           byte_done;

  assign byte_in   = {shift_reg, mosi_i};
  assign byte_done = (bit_cnt_reg == SRAP_BIT_LAST);

  // ----------------------------------------------------------------
  // Frame state, cleared whenever select is high
  // ----------------------------------------------------------------
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_reg <= SRAP_BIT_CNT_RST;
      shift_reg   <= 7'h00;
      phase_reg   <= SRAP_PH_CMD;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg   <= byte_in[6:0];
      if (byte_done) begin
        case (phase_reg)
          SRAP_PH_CMD:  phase_reg <= SRAP_PH_IDX;
          SRAP_PH_IDX:  phase_reg <= SRAP_PH_DATA;
          SRAP_PH_DATA: phase_reg <= SRAP_PH_DATA;
          default:      phase_reg <= SRAP_PH_CMD;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Header and data hand-off; not cleared by select, so the core
  // still sees the last byte after the frame ends
  // ----------------------------------------------------------------
  always_ff @(posedge sclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lk.dir     <= 1'b0;
      lk.idx     <= SRAP_IDX_RST;
      lk.data    <= SRAP_DATA_RST;
      lk.hdr_tgl <= 1'b0;
      lk.dat_tgl <= 1'b0;
    end else if (!cs_n_i && byte_done) begin
      case (phase_reg)
        SRAP_PH_CMD: begin
          lk.dir      <= byte_in[7];
          lk.idx[6:0] <= byte_in[6:0];
        end
        SRAP_PH_IDX: begin
          lk.idx[7]  <= byte_in[7];
          lk.hdr_tgl <= ~lk.hdr_tgl;
        end
        SRAP_PH_DATA: begin
          // Read frames ignore incoming bits but still pace prefetch
          if (lk.dir == SRAP_DIR_WRITE) begin
            lk.data <= byte_in;
          end
          lk.dat_tgl <= ~lk.dat_tgl;
        end
        default: lk.dat_tgl <= lk.dat_tgl;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data, changed on the falling edge
  // ----------------------------------------------------------------
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      out_reg <= SRAP_DATA_RST;
    end else if (phase_reg == SRAP_PH_DATA && !lk.dir) begin
      if (bit_cnt_reg == SRAP_BIT_CNT_RST) begin
        out_reg <= lk.rd_byte;
      end else begin
        out_reg <= {out_reg[6:0], 1'b0};
      end
    end
  end

  // Driven only while the master clocks a read frame
  assign miso_oe_o = (phase_reg == SRAP_PH_DATA) && !lk.dir;
  assign miso_o    = out_reg[7];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_idx_top_bit: assert property (@(posedge sclk_i) disable iff (cs_n_i)
    (phase_reg == SRAP_PH_IDX && byte_done)
      |=> (lk.idx[7] == $past(shift_reg[6])) && $stable(lk.idx[6:0]))
    else $error("index top bit not taken from first bit of second byte");

  a_miso_read_only: assert property (@(posedge sclk_i) disable iff (cs_n_i)
    miso_oe_o |-> (phase_reg == SRAP_PH_DATA) && (lk.dir != SRAP_DIR_WRITE))
    else $error("MISO driven outside read data phase");

  a_miso_idle_low: assert property (@(posedge sclk_i) disable iff (cs_n_i)
    !miso_oe_o |-> !miso_o)
    else $error("MISO not low outside read data phase");

endmodule

// file: rtl/srap_top.sv
// Serial register access port: SPI slave core with shared index pointer
module srap_top
  import srap_pkg::*;
(
  input  wire logic       CLK_SYS_I,
  input  wire logic       NRST_I,
  input  wire logic       SCLK_I,
  input  wire logic       CS_N_I,
  input  wire logic       MOSI_I,
  output logic            MISO_O,
  output logic            MISO_OE_O,
  output logic            REG_WR_O,
  output logic            REG_RD_O,
  output logic [7:0]      REG_ADDR_O,
  output logic [7:0]      REG_WDATA_O,
  input  wire logic [7:0] REG_RDATA_I,
  input  wire logic       I2C_IDX_LOAD_I,
  input  wire logic [7:0] I2C_IDX_I,
  input  wire logic       I2C_DATA_ACK_I,
  input  wire logic [7:0] I2C_DATA_I
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  srap_link_if lk ();

  logic [1:0] tgl_s1_reg;
  logic [1:0] tgl_s2_reg;
  logic [1:0] tgl_s3_reg;
  logic       hdr_ev;
  logic       dat_ev;
  logic       spi_act;
  logic       i2c_wr;
  logic [7:0] ptr_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic       wr_reg;
  logic       rd_reg;
  logic [7:0] rd_byte_reg;

  function automatic logic [7:0] srap_next_idx(input logic [7:0] idx);
    srap_next_idx = idx + 8'h01;
  endfunction

  // ----------------------------------------------------------------
  // Link-clock shifter
  // ----------------------------------------------------------------
  srap_spi_shift u_shift (
    .sclk_i    (SCLK_I),
    .cs_n_i    (CS_N_I),
    .nrst_i    (NRST_I),
    .mosi_i    (MOSI_I),
    .miso_o    (MISO_O),
    .miso_oe_o (MISO_OE_O),
    .lk        (lk.link)
  );

  // ----------------------------------------------------------------
  // Event crossing: toggles through two flops, then edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tgl_s1_reg <= 2'h0;
      tgl_s2_reg <= 2'h0;
      tgl_s3_reg <= 2'h0;
    end else begin
      tgl_s1_reg <= {lk.dat_tgl, lk.hdr_tgl};
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  // Index, data and direction are held steady across the crossing
  assign hdr_ev  = tgl_s2_reg[0] ^ tgl_s3_reg[0];
  assign dat_ev  = tgl_s2_reg[1] ^ tgl_s3_reg[1];
  assign spi_act = hdr_ev | dat_ev;

  // The two paths never run together; SPI wins if they ever do
  assign i2c_wr = I2C_DATA_ACK_I && !I2C_IDX_LOAD_I && !spi_act;

  // ----------------------------------------------------------------
  // Shared register index pointer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ptr_reg <= SRAP_IDX_RST;
    end else if (hdr_ev) begin
      ptr_reg <= lk.idx;
    end else if (dat_ev) begin
      ptr_reg <= srap_next_idx(ptr_reg);
    end else if (I2C_IDX_LOAD_I) begin
      ptr_reg <= I2C_IDX_I;
    end else if (i2c_wr) begin
      ptr_reg <= srap_next_idx(ptr_reg);
    end
  end

  // ----------------------------------------------------------------
  // Register file access port
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else begin
      wr_reg <= (dat_ev && lk.dir == SRAP_DIR_WRITE) || i2c_wr;
      rd_reg <= spi_act && lk.dir != SRAP_DIR_WRITE;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      addr_reg <= SRAP_IDX_RST;
    end else if (hdr_ev) begin
      addr_reg <= lk.idx;
    end else if (dat_ev) begin
      // Reads prefetch the next register for the coming byte
      addr_reg <= lk.dir ? ptr_reg : srap_next_idx(ptr_reg);
    end else if (i2c_wr) begin
      addr_reg <= ptr_reg;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wdata_reg <= SRAP_DATA_RST;
    end else if (dat_ev) begin
      wdata_reg <= lk.data;
    end else if (i2c_wr) begin
      wdata_reg <= I2C_DATA_I;
    end
  end

  // Must settle before the falling clock edge that loads it
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rd_byte_reg <= SRAP_DATA_RST;
    end else if (rd_reg) begin
      rd_byte_reg <= REG_RDATA_I;
    end
  end

  assign lk.rd_byte  = rd_byte_reg;
  assign REG_WR_O    = wr_reg;
  assign REG_RD_O    = rd_reg;
  assign REG_ADDR_O  = addr_reg;
  assign REG_WDATA_O = wdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_read_hdr;
    hdr_ev && !lk.dir;
  endsequence

  sequence s_fetch_done;
    REG_RD_O ##1 (rd_byte_reg == $past(REG_RDATA_I));
  endsequence

  sequence s_spi_wr_byte;
    dat_ev && lk.dir;
  endsequence

  property p_read_fetch;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      s_read_hdr |=> (REG_ADDR_O == $past(lk.idx)) ##0 s_fetch_done;
  endproperty

  property p_spi_write;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      s_spi_wr_byte |=> REG_WR_O && (REG_WDATA_O == $past(lk.data))
                        && (REG_ADDR_O == $past(ptr_reg));
  endproperty

  a_hdr_loads_ptr: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    hdr_ev |=> ptr_reg == $past(lk.idx))
    else $error("pointer not loaded from header index");

  a_spi_write_byte: assert property (p_spi_write)
    else $error("SPI write byte not issued at current pointer");

  a_spi_ptr_inc: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    dat_ev |=> ptr_reg == srap_next_idx($past(ptr_reg)))
    else $error("pointer did not advance after data byte");

  a_i2c_burst_inc: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    i2c_wr |=> REG_WR_O && (REG_ADDR_O == $past(ptr_reg))
               && (ptr_reg == srap_next_idx($past(ptr_reg))))
    else $error("I2C burst write did not write and advance");

  a_read_no_write: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (dat_ev && !lk.dir) |=> REG_RD_O && !REG_WR_O)
    else $error("read frame data byte caused a write");

  a_read_fetch: assert property (p_read_fetch)
    else $error("read header did not fetch indexed register");

  a_write_has_cause: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    REG_WR_O |-> $past(dat_ev) || $past(i2c_wr))
    else $error("write without a completed byte");

  a_i2c_idx_load: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (I2C_IDX_LOAD_I && !spi_act) |=> ptr_reg == $past(I2C_IDX_I))
    else $error("pointer not loaded from I2C index");

  // Single cycle holds because link events sit a whole byte apart
  a_rd_strobe_pulse: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    REG_RD_O |=> !REG_RD_O)
    else $error("read strobe longer than one cycle");

endmodule

// file: verif/srap_host_model.sv
// SPI bus master model driving the port from the host side
module srap_host_model (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // Half period; the bench raises it to run a slow host
  time half = 504;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic select();
    #(half) cs_n_o = 1'b0;
    #(half);
  endtask

  // ----------------------------------------------------------------
  // Bit shifting, MSB first
  // ----------------------------------------------------------------
  // Unenabled MISO reads back as unknown so a missing enable shows up
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--) begin
      mosi_o = tx[i];
      #(half) sclk_o = 1'b1;
      rx = {rx[6:0], (miso_oe_i === 1'b1) ? miso_i : 1'bx};
      #(half) sclk_o = 1'b0;
    end
  endtask

  // Released MOSI flips so a stale level is never mistaken for data
  task automatic deselect();
    #(half) cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #(2 * half);
  endtask
endmodule

// file: verif/tb.sv
// Self-checking bench for the serial register access port
module tb;
  import srap_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys = 1'b0;
  logic        nrst    = 1'b0;
  logic        sclk, cs_n, mosi, miso, miso_oe, reg_wr, reg_rd;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, i2c_idx, i2c_data, rx;
  logic        i2c_load = 1'b0;
  logic        i2c_ack  = 1'b0;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  int          num_errors, checks_done;
  int          seed = 32'hb1dd;
  logic [7:0]  rd_q[$];
  logic [7:0]  rd_got;
  int          rd_cnt;
  event        rd_ev;

  always #25 clk_sys = ~clk_sys;

  // Register file stand-in, answers in the strobe cycle
  assign reg_rdata = reg_addr ^ 8'hC3;

  srap_top i_dut (
    .CLK_SYS_I(clk_sys), .NRST_I(nrst), .SCLK_I(sclk), .CS_N_I(cs_n), .MOSI_I(mosi),
    .MISO_O(miso), .MISO_OE_O(miso_oe), .REG_WR_O(reg_wr), .REG_RD_O(reg_rd),
    .REG_ADDR_O(reg_addr), .REG_WDATA_O(reg_wdata), .REG_RDATA_I(reg_rdata),
    .I2C_IDX_LOAD_I(i2c_load), .I2C_IDX_I(i2c_idx), .I2C_DATA_ACK_I(i2c_ack), .I2C_DATA_I(i2c_data)
  );

  srap_host_model i_host (
    .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe)
  );

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Scoreboard: oldest expected write against each strobe
  // ----------------------------------------------------------------
  always @(negedge clk_sys) begin
    if (reg_rd === 1'b1) rd_cnt++;
    if (reg_wr === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("[ERR] %0t write strobe with nothing sent", $time);
      end else begin
        e = exp_q.pop_front();
        check(reg_addr, e[15:8]);
        check(reg_wdata, e[7:0]);
      end
    end
  end

  // Read bytes against the oldest expected read
  always @(rd_ev) begin
    if (rd_q.size() == 0) begin
      num_errors++;
      $display("[ERR] %0t read byte with nothing expected", $time);
    end else begin
      check(rd_got, rd_q.pop_front());
    end
  end

  // Header then n data bytes, then part bits of a byte that must be dropped
  task automatic spi_wr(input logic [7:0] idx, input int n, input int part);
    logic [7:0] d;
    int         c0;
    c0 = rd_cnt;
    i_host.select();
    i_host.shift({1'b1, idx[6:0]}, 8, rx);
    i_host.shift({idx[7], 7'($random(seed))}, 8, rx);
    for (int k = 0; k < n; k++) begin
      d = 8'($random(seed));
      exp_q.push_back({8'(idx + k), d});
      i_host.shift(d, 8, rx);
    end
    if (part > 0) i_host.shift(8'($random(seed)), part, rx);
    i_host.deselect();
    check(8'(rd_cnt - c0), 8'h00);
  endtask

  // Header strobe plus one prefetch strobe per data byte
  task automatic spi_rd(input logic [7:0] idx, input int n);
    int c0;
    c0 = rd_cnt;
    i_host.select();
    i_host.shift({1'b0, idx[6:0]}, 8, rx);
    i_host.shift({idx[7], 7'($random(seed))}, 8, rx);
    for (int k = 0; k < n; k++) begin
      rd_q.push_back(8'(idx + k) ^ 8'hC3);
      i_host.shift(8'($random(seed)), 8, rx);
      rd_got = rx;
      -> rd_ev;
    end
    i_host.deselect();
    check(8'(rd_cnt - c0), 8'(n + 1));
  endtask

  // Load pointer, then n acknowledged bytes back to back
  task automatic i2c_wr(input logic [7:0] idx, input int n);
    @(negedge clk_sys);
    i2c_load = 1'b1;
    i2c_idx  = idx;
    for (int k = 0; k < n; k++) begin
      @(negedge clk_sys);
      i2c_load = 1'b0;
      i2c_ack  = 1'b1;
      i2c_data = 8'($random(seed));
      exp_q.push_back({8'(idx + k), i2c_data});
    end
    @(negedge clk_sys) i2c_ack = 1'b0;
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    i2c_idx  = 8'h00;
    i2c_data = 8'h00;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) nrst = 1'b1;
    spi_wr(8'hFE, 3, 0);
    spi_wr(8'h3C, 1, 5);
    i_host.select();
    i_host.shift(8'hFF, 5, rx);
    i_host.deselect();
    spi_wr(8'($random(seed)), 2, 0);
    spi_rd(8'h7F, 3);
    i_host.half = 1500;
    spi_wr(8'($random(seed)), 2, 0);
    spi_rd(8'($random(seed)), 2);
    i_host.half = 504;
    i2c_wr(8'hFF, 3);
    // Mid-run reset with select idle; outputs must fall to rest
    @(negedge clk_sys) nrst = 1'b0;
    @(negedge clk_sys);
    check(reg_addr, SRAP_IDX_RST);
    check(reg_wdata, SRAP_DATA_RST);
    check({4'h0, miso_oe, miso, reg_wr, reg_rd}, 8'h00);
    @(negedge clk_sys) nrst = 1'b1;
    for (int t = 0; t < 3; t++) spi_wr(8'($random(seed)), 1 + t, 0);
    for (int w = 0; w < 100 && exp_q.size() > 0; w++) @(negedge clk_sys);
    if (exp_q.size() > 0) begin
      num_errors++;
      $display("[ERR] %0t writes missing %0d", $time, exp_q.size());
    end
    end_sim();
  end

  // Cuts a hang short
  initial begin
    #3ms;
    num_errors++;
    $display("[ERR] %0t run timed out", $time);
    end_sim();
  end
endmodule
